// ===== src/ctp_core.sv
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module ctp_core
    import ctp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Register port
    input  wire logic [1:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    // Request from the execution engine
    input  wire logic        req_valid,
    input  wire ctp_req_t    req_kind,
    input  wire logic [2:0]  req_class,
    input  wire logic [7:0]  req_length,
    input  wire logic        req_dir_out,
    input  wire logic [2:0]  req_reg,
    input  wire logic        exc_enabled,
    input  wire logic        dual_no_ca,
    input  wire logic        busy,
    input  wire logic        cond_true,
    // Status back to the engine
    output logic             req_taken,
    output logic             req_served,
    output logic      [31:0] list_data,
    output logic             req_bad
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    ctp_state_t  state_reg, state_next;
    logic [15:0] resp_reg, resp_next;
    logic        sreg_reg, sreg_next;
    logic [31:0] rdata_next;
    logic        taken_reg, taken_next;
    logic        served_reg, served_next;
    logic [31:0] list_reg, list_next;
    logic        bad_reg, bad_next;
    logic [15:0] fmt_word;
    logic        fmt_legal;
    logic [15:0] null_word;

    // ----------------------------------------------------------------
    // Formatter
    // ----------------------------------------------------------------
    ctp_fmt u_fmt (
        .kind        (req_kind),
        .op_class    (req_class),
        .length      (req_length),
        .exc_enabled (exc_enabled),
        .dual_no_ca  (dual_no_ca),
        .dir_out     (req_dir_out),
        .reg_num     (req_reg),
        .word        (fmt_word),
        .legal       (fmt_legal)
    );

    // Null response with idle and condition bits
    always_comb begin
        null_word = 16'h0000;
        null_word[13:9] = CTP_NULL_PAT;
        null_word[CTP_IA_BIT] = busy;
        null_word[CTP_PF_BIT] = !busy;
        null_word[CTP_TF_BIT] = cond_true;
    end

    // ----------------------------------------------------------------
    // Dialog state next values
    // ----------------------------------------------------------------
    always_comb begin
        state_next  = state_reg;
        resp_next   = resp_reg;
        sreg_next   = sreg_reg;
        taken_next  = 1'b0;
        served_next = 1'b0;
        list_next   = list_reg;
        bad_next    = bad_reg;
        rdata_next  = 32'h0000_0000;
        if (rd) begin
            case (addr)
                CTP_ADDR_RESP:    rdata_next = {16'h0000, resp_reg};
                CTP_ADDR_OPERAND: rdata_next = list_reg;
                CTP_ADDR_STATUS:  rdata_next = {29'h0, bad_reg, sreg_reg,
                                                state_reg == CTP_ST_SHOW};
                default:          rdata_next = 32'h0000_0000;
            endcase
        end
        case (state_reg)
            CTP_ST_IDLE: begin
                resp_next = null_word;
                if (req_valid) begin
                    resp_next  = fmt_word;
                    sreg_next  = req_kind == CTP_REQ_SREG;
                    bad_next   = !fmt_legal;
                    taken_next = 1'b1;
                    state_next = CTP_ST_SHOW;
                end
            end
            CTP_ST_SHOW: begin
                if (rd && addr == CTP_ADDR_RESP) begin
                    resp_next = null_word;
                    state_next = sreg_reg ? CTP_ST_WAIT : CTP_ST_IDLE;
                end
            end
            CTP_ST_WAIT: begin
                resp_next = null_word;
                if (wr && addr == CTP_ADDR_OPERAND) begin
                    list_next   = wdata;
                    served_next = 1'b1;
                    sreg_next   = 1'b0;
                    state_next  = CTP_ST_IDLE;
                end
            end
            default: begin
                state_next = CTP_ST_IDLE;
                resp_next  = null_word;
            end
        endcase
    end

    // Register the dialog state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg  <= CTP_ST_IDLE;
            resp_reg   <= CTP_RESP_RST;
            sreg_reg   <= 1'b0;
            rdata      <= 32'h0000_0000;
            taken_reg  <= 1'b0;
            served_reg <= 1'b0;
            list_reg   <= 32'h0000_0000;
            bad_reg    <= 1'b0;
        end else begin
            state_reg  <= state_next;
            resp_reg   <= resp_next;
            sreg_reg   <= sreg_next;
            rdata      <= rdata_next;
            taken_reg  <= taken_next;
            served_reg <= served_next;
            list_reg   <= list_next;
            bad_reg    <= bad_next;
        end
    end

    // Outputs straight from flops
    assign req_taken  = taken_reg;
    assign req_served = served_reg;
    assign list_data  = list_reg;
    assign req_bad    = bad_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence resp_read_s;
        rd && addr == CTP_ADDR_RESP && state_reg == CTP_ST_SHOW;
    endsequence

    sequence null_after_s;
        resp_reg[15:9] == {2'b00, CTP_NULL_PAT};
    endsequence

    discard_once_a: assert property (@(posedge clk) disable iff (!nrst)
        resp_read_s |=> null_after_s)
        else $error("request not discarded after read");

    stable_show_a: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == CTP_ST_SHOW && $past(state_reg) == CTP_ST_SHOW |-> $stable(resp_reg))
        else $error("request word changed while shown");

    ea_pattern_a: assert property (@(posedge clk) disable iff (!nrst)
        req_valid && state_reg == CTP_ST_IDLE && req_kind == CTP_REQ_EA
        |=> resp_reg[12:11] == CTP_EA_PAT && resp_reg[7:0] == $past(req_length))
        else $error("transfer request fields wrong");

    arith_class_a: assert property (@(posedge clk) disable iff (!nrst)
        req_valid && state_reg == CTP_ST_IDLE && req_kind == CTP_REQ_EA
        && req_class == CTP_OC_ARITH_MEM && req_length == 8'h08
        |=> resp_reg[10:8] == CTP_EA_MEM && !resp_reg[CTP_DIR_BIT])
        else $error("arithmetic source class wrong");

    pc_exc_a: assert property (@(posedge clk) disable iff (!nrst)
        req_valid && state_reg == CTP_ST_IDLE && req_kind == CTP_REQ_EA
        && req_class == CTP_OC_ARITH_MEM
        |=> resp_reg[CTP_PC_BIT] == $past(exc_enabled))
        else $error("pass counter flag wrong");

    store_dir_a: assert property (@(posedge clk) disable iff (!nrst)
        req_valid && state_reg == CTP_ST_IDLE && req_kind == CTP_REQ_EA
        && req_class == CTP_OC_STORE && req_length == 8'h04
        |=> resp_reg[CTP_DIR_BIT] && !resp_reg[CTP_PC_BIT] && resp_reg[10:8] == CTP_EA_DAT_ALT)
        else $error("store request fields wrong");

    sreg_wait_a: assert property (@(posedge clk) disable iff (!nrst)
        (resp_read_s and sreg_reg) ##1 (!(wr && addr == CTP_ADDR_OPERAND))[*2]
        |-> state_reg == CTP_ST_WAIT && resp_reg[15:9] == {2'b00, CTP_NULL_PAT})
        else $error("single register request not held null");

    mreg_len_a: assert property (@(posedge clk) disable iff (!nrst)
        req_valid && state_reg == CTP_ST_IDLE && req_kind == CTP_REQ_MREG
        |=> resp_reg[7:0] == CTP_MREG_LEN && resp_reg[12:8] == CTP_MREG_PAT)
        else $error("multiple register word wrong");

    null_idle_a: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == CTP_ST_IDLE && !req_valid ##1 state_reg == CTP_ST_IDLE
        |-> resp_reg[CTP_PF_BIT] == !$past(busy))
        else $error("null idle bit wrong");

    sequence ea_load_s;
        req_valid && state_reg == CTP_ST_IDLE && req_kind == CTP_REQ_EA;
    endsequence

    arith_small_a: assert property (@(posedge clk) disable iff (!nrst)
        ea_load_s ##0 (req_class == CTP_OC_ARITH_MEM && (req_length == 8'h01
        || req_length == 8'h02 || req_length == 8'h04))
        |=> resp_reg[CTP_CA_BIT] && !resp_reg[CTP_DIR_BIT] && resp_reg[10:8] == CTP_EA_DAT)
        else $error("arithmetic source small class wrong");

    store_big_a: assert property (@(posedge clk) disable iff (!nrst)
        ea_load_s ##0 (req_class == CTP_OC_STORE && (req_length == 8'h08 || req_length == 8'h0c))
        |=> resp_reg[14:13] == 2'b01 && resp_reg[10:8] == CTP_EA_MEM_ALT)
        else $error("store request large class wrong");

    ctl_load_a: assert property (@(posedge clk) disable iff (!nrst)
        ea_load_s ##0 (req_class == CTP_OC_CTL_LOAD)
        |=> resp_reg[15:13] == 3'b100 && resp_reg[10:8] ==
            (($past(req_length) == CTP_CREG_BYTES) ? CTP_EA_ANY : CTP_EA_MEM))
        else $error("control load request wrong");

    ctl_store_a: assert property (@(posedge clk) disable iff (!nrst)
        ea_load_s ##0 (req_class == CTP_OC_CTL_STORE)
        |=> resp_reg[15:13] == 3'b101 && resp_reg[10:8] ==
            (($past(req_length) == CTP_CREG_BYTES) ? CTP_EA_ALT : CTP_EA_MEM_ALT))
        else $error("control store request wrong");

    bad_len_a: assert property (@(posedge clk) disable iff (!nrst)
        ea_load_s ##0 ((req_class == CTP_OC_CTL_LOAD || req_class == CTP_OC_CTL_STORE)
        && req_length != 8'h04 && req_length != 8'h08 && req_length != 8'h0c)
        |=> bad_reg)
        else $error("control length not refused");

    ca_set_a: assert property (@(posedge clk) disable iff (!nrst)
        ea_load_s ##0 !dual_no_ca
        |=> resp_reg[CTP_CA_BIT])
        else $error("come again flag not set");

    ca_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        ea_load_s ##0 (dual_no_ca && (req_length == 8'h08 || req_length == 8'h0c)
        && (req_class == CTP_OC_ARITH_MEM || req_class == CTP_OC_STORE))
        |=> !resp_reg[CTP_CA_BIT])
        else $error("come again flag not cleared");

    out_class_a: assert property (@(posedge clk) disable iff (!nrst)
        ea_load_s ##0 fmt_legal
        |=> resp_reg[10] == !resp_reg[CTP_DIR_BIT])
        else $error("class code does not suit direction");

    imm_len_a: assert property (@(posedge clk) disable iff (!nrst)
        ea_load_s ##0 fmt_legal
        |=> resp_reg[CTP_DIR_BIT] || resp_reg[7:0] == 8'h01 || !resp_reg[0])
        else $error("inward length neither one nor even");

    sreg_word_a: assert property (@(posedge clk) disable iff (!nrst)
        req_valid && state_reg == CTP_ST_IDLE && req_kind == CTP_REQ_SREG
        |=> resp_reg == {3'b100, CTP_SREG_PAT, 1'b0, $past(req_reg)})
        else $error("single register word wrong");

    mreg_dir_a: assert property (@(posedge clk) disable iff (!nrst)
        req_valid && state_reg == CTP_ST_IDLE && req_kind == CTP_REQ_MREG
        |=> resp_reg[15:13] == {2'b10, $past(req_dir_out)})
        else $error("multiple register flags wrong");

    null_cond_a: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == CTP_ST_IDLE && !req_valid
        |=> resp_reg[CTP_TF_BIT] == $past(cond_true))
        else $error("null condition bit wrong");

    taken_a: assert property (@(posedge clk) disable iff (!nrst)
        req_valid && state_reg == CTP_ST_IDLE
        |=> req_taken && state_reg == CTP_ST_SHOW)
        else $error("request not loaded");

    wait_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == CTP_ST_WAIT && !(wr && addr == CTP_ADDR_OPERAND)
        |=> !req_taken && state_reg == CTP_ST_WAIT && resp_reg[15:9] == {2'b00, CTP_NULL_PAT})
        else $error("wait state left early");

    serve_a: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == CTP_ST_WAIT && wr && addr == CTP_ADDR_OPERAND
        |=> req_served && list_data == $past(wdata) && state_reg == CTP_ST_IDLE)
        else $error("operand write not served");

endmodule

// ===== src/ctp_pkg.sv
package ctp_pkg;

    // ----------------------------------------------------------------
    // Response word fields
    // ----------------------------------------------------------------
    localparam int CTP_CA_BIT   = 15;
    localparam int CTP_PC_BIT   = 14;
    localparam int CTP_DIR_BIT  = 13;
    localparam int CTP_IA_BIT   = 8;
    localparam int CTP_PF_BIT   = 1;
    localparam int CTP_TF_BIT   = 0;

    // Fixed patterns of each primitive
    localparam logic [1:0]  CTP_EA_PAT     = 2'h2;    // bits 12..11 = 10
    localparam logic [8:0]  CTP_SREG_PAT   = 9'h0c0;  // bits 12..4 = 011000000
    localparam logic [4:0]  CTP_MREG_PAT   = 5'h01;   // bits 12..8 = 00001
    localparam logic [4:0]  CTP_NULL_PAT   = 5'h04;   // bits 13..9 = 00100
    localparam logic [7:0]  CTP_MREG_LEN   = 8'h0c;   // Twelve bytes per register
    localparam logic [7:0]  CTP_CREG_BYTES = 8'h04;   // Bytes per control register

    // Address class codes
    localparam logic [2:0] CTP_EA_CTL_ALT = 3'h0;
    localparam logic [2:0] CTP_EA_DAT_ALT = 3'h1;
    localparam logic [2:0] CTP_EA_MEM_ALT = 3'h2;
    localparam logic [2:0] CTP_EA_ALT     = 3'h3;
    localparam logic [2:0] CTP_EA_CTL     = 3'h4;
    localparam logic [2:0] CTP_EA_DAT     = 3'h5;
    localparam logic [2:0] CTP_EA_MEM     = 3'h6;
    localparam logic [2:0] CTP_EA_ANY     = 3'h7;

    // Operation classes served here
    localparam logic [2:0] CTP_OC_ARITH_MEM = 3'h2;
    localparam logic [2:0] CTP_OC_STORE     = 3'h3;
    localparam logic [2:0] CTP_OC_CTL_LOAD  = 3'h4;
    localparam logic [2:0] CTP_OC_CTL_STORE = 3'h5;

    // Register port
    localparam logic [1:0] CTP_ADDR_RESP   = 2'h0;
    localparam logic [1:0] CTP_ADDR_OPERAND= 2'h1;
    localparam logic [1:0] CTP_ADDR_STATUS = 2'h2;
    localparam logic [15:0] CTP_RESP_RST   = 16'h0802;

    typedef enum logic [1:0] {
        CTP_REQ_EA   = 2'b00,
        CTP_REQ_SREG = 2'b01,
        CTP_REQ_MREG = 2'b10
    } ctp_req_t;

    typedef enum logic [1:0] {
        CTP_ST_IDLE = 2'b00,
        CTP_ST_SHOW = 2'b01,
        CTP_ST_WAIT = 2'b10
    } ctp_state_t;

endpackage

// ===== src/ctp_fmt.sv
`timescale 1ns/1ps
// Combinational formatter of request words
module ctp_fmt
    import ctp_pkg::*;
(
    // Request description
    input  wire ctp_req_t    kind,
    input  wire logic [2:0]  op_class,
    input  wire logic [7:0]  length,
    input  wire logic        exc_enabled,
    input  wire logic        dual_no_ca,
    input  wire logic        dir_out,
    input  wire logic [2:0]  reg_num,
    // Result
    output logic      [15:0] word,
    output logic             legal
);

    // ----------------------------------------------------------------
    // Word assembly
    // ----------------------------------------------------------------
    function automatic logic is_small(input logic [7:0] n);
        return (n == 8'h01) || (n == 8'h02) || (n == 8'h04);
    endfunction

    always_comb begin
        logic ca;
        logic pc;
        logic dr;
        logic [2:0] cls;
        ca    = 1'b1;
        pc    = 1'b0;
        dr    = 1'b0;
        cls   = CTP_EA_ANY;
        legal = 1'b1;
        word  = 16'h0000;
        case (kind)
            CTP_REQ_EA: begin
                case (op_class)
                    CTP_OC_ARITH_MEM: begin
                        pc  = exc_enabled;
                        ca  = !(dual_no_ca && !is_small(length));
                        cls = is_small(length) ? CTP_EA_DAT : CTP_EA_MEM;
                        legal = is_small(length) || length == 8'h08 || length == 8'h0c;
                    end
                    CTP_OC_STORE: begin
                        dr  = 1'b1;
                        ca  = !(dual_no_ca && !is_small(length));
                        cls = is_small(length) ? CTP_EA_DAT_ALT : CTP_EA_MEM_ALT;
                        legal = is_small(length) || length == 8'h08 || length == 8'h0c;
                    end
                    CTP_OC_CTL_LOAD: begin
                        cls = (length == CTP_CREG_BYTES) ? CTP_EA_ANY : CTP_EA_MEM;
                        legal = length == 8'h04 || length == 8'h08 || length == 8'h0c;
                    end
                    CTP_OC_CTL_STORE: begin
                        dr  = 1'b1;
                        cls = (length == CTP_CREG_BYTES) ? CTP_EA_ALT : CTP_EA_MEM_ALT;
                        legal = length == 8'h04 || length == 8'h08 || length == 8'h0c;
                    end
                    default: legal = 1'b0;
                endcase
                word = {ca, pc, dr, CTP_EA_PAT, cls, length};
            end
            CTP_REQ_SREG: begin
                word = {1'b1, 1'b0, 1'b0, CTP_SREG_PAT, 1'b0, reg_num};
            end
            CTP_REQ_MREG: begin
                word = {1'b1, 1'b0, dir_out, CTP_MREG_PAT, CTP_MREG_LEN};
            end
            default: legal = 1'b0;
        endcase
    end

endmodule

// ===== test/ctp_mpu_model.sv
`timescale 1ns/1ps
// Main processor side of the register port
module ctp_mpu_model (
    // Clock
    input  wire logic        clk,
    // Register port
    output logic      [1:0]  addr,
    output logic      [31:0] wdata,
    output logic             wr,
    output logic             rd
);
    logic [31:0] dreg [8];
    logic [31:0] ea_ptr;

    // Idle bus values
    initial begin
        addr = 2'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        ea_ptr = 32'h0;
    end

    // One-cycle read
    task automatic bus_read(input logic [1:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // One-cycle write, data scrambled once released
    task automatic bus_write(input logic [1:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask

    // Named data register sent as one long word
    task automatic put_reg(input logic [2:0] r);
        bus_write(2'h1, dreg[r]);
    endtask

    // Transfer request service: abort on a bad mode, else send the operand if inward and step ea_ptr
    task automatic serve_ea(input logic out, input logic [7:0] len, input logic mode_ok,
        input logic sp);
        if (!mode_ok) begin
            bus_write(2'h2, 32'h1);
        end else begin
            if (!out) begin
                for (int k = 0; k < (len + 3) / 4; k++) bus_write(2'h1, dreg[k]);
            end
            ea_ptr = ea_ptr + ((sp && len == 8'h01) ? 32'h2 : {24'h0, len});
        end
    endtask

    // Register list move, long words of each selected register
    task automatic serve_mreg(input logic [7:0] list, input logic [7:0] len);
        for (int k = 0; k < 8; k++) begin
            if (list[k]) repeat (len / 4) bus_write(2'h1, dreg[k]);
        end
    endtask
endmodule

// ===== test/ctp_core_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("Error at %0t: got %h expected %h", $time, a, e); end end
module ctp_core_test
    import ctp_pkg::*;
();
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [1:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        req_valid = 1'b0;
    ctp_req_t    req_kind = CTP_REQ_EA;
    logic [2:0]  req_class = 3'h2;
    logic [7:0]  req_length = 8'h04;
    logic        req_dir_out = 1'b0;
    logic [2:0]  req_reg = 3'h0;
    logic        exc_enabled = 1'b0;
    logic        dual_no_ca = 1'b0;
    logic        busy = 1'b0;
    logic        cond_true = 1'b0;
    logic        req_taken;
    logic        req_served;
    logic [31:0] list_data;
    logic        req_bad;
    int          fail_count = 0;
    int          n_checks = 0;
    int          seed = 32'hdaa2;
    int          cyc = 0;
    int          i;
    int          c;
    int          n;
    logic [31:0] r32;
    logic        rd_q = 1'b0;
    logic [32:0] note;
    logic [32:0] notes [$];
    logic [7:0]  lens [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h0c};

    ctp_core dut (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .req_valid, .req_kind,
        .req_class, .req_length, .req_dir_out, .req_reg, .exc_enabled, .dual_no_ca,
        .busy, .cond_true, .req_taken, .req_served, .list_data, .req_bad);
    ctp_mpu_model mpu (.clk, .addr, .wdata, .wr, .rd);

    // Clock
    always #4 clk = ~clk;

    // Expected transfer request word
    function automatic logic [15:0] exp_ea(input logic [2:0] k, input logic [7:0] l,
        input logic e, input logic d);
        logic       big;
        logic [2:0] v;
        big = (l == 8'h08) || (l == 8'h0c);
        case (k)
            3'h2: v = big ? 3'h6 : 3'h5;
            3'h3: v = big ? 3'h2 : 3'h1;
            3'h4: v = big ? 3'h6 : 3'h7;
            default: v = big ? 3'h2 : 3'h3;
        endcase
        return {!(d && big && k < 3'h4), (k == 3'h2) && e, k[0], 2'h2, v, l};
    endfunction

    // Expected null word
    function automatic logic [31:0] nullw(input logic b, input logic t);
        return {16'h0, 5'h01, 2'h0, b, 6'h0, ~b, t};
    endfunction

    // Read with a note of the expected data
    task automatic expect_rd(input logic [1:0] a, input logic [31:0] v, input bit k = 1);
        notes.push_back({k, v});
        mpu.bus_read(a);
    endtask

    // Request from the engine, random side inputs
    task automatic issue(input ctp_req_t k, input logic [2:0] cl, input logic [7:0] l,
        input logic d, input logic [2:0] r);
        @(posedge clk);
        r32 = $random(seed);
        req_valid <= 1'b1;
        req_kind <= k;
        req_class <= cl;
        req_length <= l;
        req_dir_out <= d;
        req_reg <= r;
        exc_enabled <= r32[0];
        dual_no_ca <= r32[1];
        busy <= r32[2];
        cond_true <= r32[3];
        @(posedge clk);
        req_valid <= 1'b0;
        for (i = 0; i < 8 && req_taken !== 1'b1; i++) @(posedge clk);
        `CHK(req_taken, 1'b1)
    endtask

    // Verdict
    task automatic tally_and_finish();
        $display("Checks made %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Read data compared one cycle after each read
    always @(posedge clk) begin
        if (rd_q) begin
            note = notes.pop_front();
            if (note[32]) `CHK(rdata, note[31:0])
        end
        rd_q <= rd;
    end

    // Hang limit
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        for (i = 0; i < 8; i++) mpu.dreg[i] = $random(seed);
        expect_rd(CTP_ADDR_RESP, nullw(1'b0, 1'b0));
        expect_rd(2'h3, 32'h0);
        for (c = 2; c < 6; c++) begin
            for (n = 0; n < 5; n++) begin
                if (c > 3 && n < 2) continue;
                issue(CTP_REQ_EA, c[2:0], lens[n], 1'b0, 3'h0);
                `CHK(req_bad, 1'b0)
                repeat (n) @(posedge clk);
                expect_rd(CTP_ADDR_RESP, {16'h0, exp_ea(c[2:0], lens[n], exc_enabled,
                    dual_no_ca)});
                expect_rd(CTP_ADDR_RESP, nullw(busy, cond_true));
                mpu.serve_ea(c[0], lens[n], n != 2, n == 0);
            end
        end
        `CHK(list_data, 32'h0)
        // Dynamic list fetch, request ignored while waiting
        issue(CTP_REQ_SREG, 3'h2, 8'h04, 1'b0, 3'h5);
        expect_rd(CTP_ADDR_RESP, {16'h0, 13'h1180, 3'h5});
        expect_rd(CTP_ADDR_RESP, nullw(busy, cond_true));
        expect_rd(CTP_ADDR_STATUS, 32'h2);
        @(posedge clk);
        req_valid <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
        repeat (3) begin
            @(posedge clk);
            `CHK(req_taken, 1'b0)
        end
        mpu.put_reg(3'h5);
        for (i = 0; i < 8 && req_served !== 1'b1; i++) @(posedge clk);
        `CHK(req_served, 1'b1)
        `CHK(list_data, mpu.dreg[5])
        expect_rd(CTP_ADDR_RESP, nullw(busy, cond_true));
        // Register list moves in both directions
        for (c = 0; c < 2; c++) begin
            issue(CTP_REQ_MREG, 3'h2, 8'h04, c[0], 3'h0);
            expect_rd(CTP_ADDR_RESP, {16'h0, 2'h2, c[0], 5'h01, 8'h0c});
            expect_rd(CTP_ADDR_RESP, nullw(busy, cond_true));
            mpu.serve_mreg(mpu.dreg[5][7:0], 8'h0c);
        end
        `CHK(list_data, mpu.dreg[5])
        // Control load with a length that no register count gives
        issue(CTP_REQ_EA, 3'h4, 8'h02, 1'b0, 3'h0);
        for (i = 0; i < 8 && req_bad !== 1'b1; i++) @(posedge clk);
        `CHK(req_bad, 1'b1)
        tally_and_finish();
    end
endmodule
